/* File: design/tsc_pkg.sv */
// tsc_pkg: constants and types for the transactional system-register bank.
// assumes a single aclk domain and an AXI4-Lite master driving the bank.
// How it works
// (R1) granule field reports log2 words of granule
// (R2) software assumes 512 words when field zero
// (R3) granule never reports one or above nine
// (R4) feature field reads 0000 or 0001
// (R5) walk-disable plus miss: fail, no walk
// (R6) upper bit upper base, lower bit lower
// (R7) transactional loads/stores are affected accesses
// (R8) vector non-fault and later gather elements affected
// (R9) walk-disable bits read zero without extensions
// (R10) syndrome holds destination register in [9:5]
// (R11) el0 trivial bit fails el0 starts
// (R12) host plus trap-general masks el0 bits
// (R13) el1 trivial bit fails el1 starts
// (R14) el0 start-enable zero traps to el1
// (R15) no enable trap when start is undefined
// (R16) el1 start-enable zero traps el1 start
// (R17) el1 control bits reset unknown, else zero
// (R18) failure discards state, writes nonzero cause
// (R19) priority: undefined, then trap, then trivial
package tsc_pkg;
   // word byte offsets, each 64-bit register split in low/high words
   localparam logic [7:0] TSC_OFF_CTR_LO = 8'h00;
   localparam logic [7:0] TSC_OFF_CTR_HI = 8'h04;
   localparam logic [7:0] TSC_OFF_ISA_LO = 8'h08;
   localparam logic [7:0] TSC_OFF_ISA_HI = 8'h0C;
   localparam logic [7:0] TSC_OFF_TC1_LO = 8'h10;
   localparam logic [7:0] TSC_OFF_TC1_HI = 8'h14;
   localparam logic [7:0] TSC_OFF_TC2_LO = 8'h18;
   localparam logic [7:0] TSC_OFF_TC2_HI = 8'h1C;
   localparam logic [7:0] TSC_OFF_SC1_LO = 8'h20;
   localparam logic [7:0] TSC_OFF_SC1_HI = 8'h24;
   localparam logic [7:0] TSC_OFF_HYP = 8'h28;
   localparam logic [7:0] TSC_OFF_STAT = 8'h2C;
   localparam logic [7:0] TSC_OFF_IEN = 8'h30;
   localparam logic [7:0] TSC_OFF_ICLR = 8'h34;
   localparam logic [7:0] TSC_OFF_SYND = 8'h38;
   localparam logic [7:0] TSC_OFF_CAUSE = 8'h3C;
   // field positions (64-bit register bit numbers; rd position within the 25-bit syndrome)
   localparam int TSC_GRAN_LSB = 20;
   localparam int TSC_FEAT_LSB = 24;
   localparam int TSC_LWD_BIT = 53;
   localparam int TSC_UWD_BIT = 54;
   localparam int TSC_T0_BIT = 50;
   localparam int TSC_T1_BIT = 51;
   localparam int TSC_E0_BIT = 52;
   localparam int TSC_E1_BIT = 53;
   localparam int TSC_SYN_RD_LSB = 5;
   // values
   localparam logic [3:0] TSC_FEAT_NONE = 4'h0;
   localparam logic [3:0] TSC_FEAT_ALL = 4'h1;
   localparam logic [3:0] TSC_GRAN_MAX_LEGAL = 4'h9;
   localparam logic [5:0] TSC_EXC_CLASS_START = 6'h1B;
   localparam logic [7:0] TSC_CAUSE_TRIVIAL = 8'h01;
   localparam logic [31:0] TSC_RESET_WORD = 32'h0000_0000;
   localparam logic [3:0] TSC_HYP_RESET = 4'hC; // both higher-level tx enables on
   // status bit positions
   localparam int TSC_EV_TRAP = 0;
   localparam int TSC_EV_TRIV = 1;
   localparam int TSC_EV_UNDEF = 2;
   localparam int TSC_EV_WFAIL = 3;
   localparam int TSC_NEV = 4;
   // exception levels
   typedef enum logic [1:0] {TSC_EL0, TSC_EL1, TSC_EL2, TSC_EL3} tsc_el_type;
   // outcome of a start attempt
   typedef enum logic [1:0] {TSC_GO, TSC_UNDEF, TSC_TRAP, TSC_TRIV} tsc_res_type;
   // start request carrier
   typedef struct packed {
      logic valid;
      tsc_el_type el;
      logic [4:0] rd;
   } tsc_start_type;
   // memory access carrier for walk gating
   typedef struct packed {
      logic valid;
      logic tlb_miss;
      logic upper;
      logic el2_regime;
      logic from_el0;
      logic transactional;
      logic nf_contig;
      logic ff_gather_later;
   } tsc_acc_type;
   // start result carrier
   typedef struct packed {
      logic valid;
      tsc_res_type res;
      logic [7:0] cause;
      logic [24:0] syndrome;
   } tsc_result_type;
endpackage : tsc_pkg

/* File: design/tsc_regs.sv */
// tsc_regs: transactional system-register bank with AXI4-Lite slave,
// start gating, walk-disable gating and an event interrupt.
// assumes all inputs come from logic on aclk; the 64-bit registers are split into low/high words.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tsc_regs #(
   parameter bit HAS_TX = 1'b1,        // transactional extension present
   parameter bit HAS_VEC = 1'b1,       // vector extension present
   parameter logic [3:0] GRANULE_LOG2 = 4'h4,   // granule log2 words, plain default
   parameter bit RESET_EL1 = 1'b1      // element resets into el1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire tsc_pkg::tsc_start_type start_req,
   output tsc_pkg::tsc_result_type start_res,
   input wire tsc_pkg::tsc_acc_type acc_req,
   output logic acc_walk,
   output logic acc_fail,
   output logic irq
);
   import tsc_pkg::*;

   localparam bit WD_PRESENT = HAS_TX | HAS_VEC;

   // write-combined byte enables into a word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // stored registers
   logic [63:0] tc1_q;     // translation_control_el1
   logic [63:0] tc2_q;     // translation_control_el2
   logic [63:0] sc1_q;     // system_control_el1
   logic [3:0] hyp_q;      // {secure tx enable, hyp tx enable, trap_general, host_at_el2}
   logic [TSC_NEV-1:0] stat_q;   // sticky events
   logic [TSC_NEV-1:0] ien_q;    // event enables
   logic [24:0] synd_q;    // last syndrome
   logic [7:0] cause_q;    // last failure cause

   // writable mask on the 64-bit registers
   localparam logic [63:0] TC_MASK = WD_PRESENT ?
      ((64'h1 << TSC_UWD_BIT) | (64'h1 << TSC_LWD_BIT)) : 64'h0; // [R9]
   localparam logic [63:0] SC_MASK = HAS_TX ? ((64'h1 << TSC_T0_BIT) |
      (64'h1 << TSC_T1_BIT) | (64'h1 << TSC_E0_BIT) | (64'h1 << TSC_E1_BIT)) : 64'h0;

   // read-only identification values
   logic [63:0] ctr_val;
   logic [63:0] isa_val;
   always_comb begin
      ctr_val = 64'h0;
      // reserved encodings are replaced by "no information"
      ctr_val[TSC_GRAN_LSB +: 4] = (GRANULE_LOG2 == 4'h1 || GRANULE_LOG2 > TSC_GRAN_MAX_LEGAL) ?
         4'h0 : GRANULE_LOG2; // [R1] [R3]
      isa_val = 64'h0;
      // hidden when either higher level makes the instructions undefined
      isa_val[TSC_FEAT_LSB +: 4] = (HAS_TX && hyp_q[2] && hyp_q[3]) ?
         TSC_FEAT_ALL : TSC_FEAT_NONE; // [R4]
   end

   // write channel: accept address and data in either order
   logic aw_have_q, w_have_q;
   logic [7:0] aw_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic wr_go;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

   // address and data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         wd_q <= TSC_RESET_WORD;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response; unmapped or read-only addresses answer SLVERR
   logic wr_ok;
   always_comb begin
      unique case (aw_q)
         TSC_OFF_TC1_LO, TSC_OFF_TC1_HI, TSC_OFF_TC2_LO, TSC_OFF_TC2_HI,
         TSC_OFF_SC1_LO, TSC_OFF_SC1_HI, TSC_OFF_HYP, TSC_OFF_IEN, TSC_OFF_ICLR: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register updates
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tc1_q <= 64'h0;
         tc2_q <= 64'h0;
         // unknown at reset is modelled as zero; reserved otherwise anyway
         sc1_q <= 64'h0; // [R17]
         hyp_q <= TSC_HYP_RESET;
         ien_q <= '0;
      end else if (wr_go) begin
         unique case (aw_q)
            TSC_OFF_TC1_LO: tc1_q[31:0] <= merge(tc1_q[31:0], wd_q, ws_q) & TC_MASK[31:0];
            TSC_OFF_TC1_HI: tc1_q[63:32] <= merge(tc1_q[63:32], wd_q, ws_q) & TC_MASK[63:32];
            TSC_OFF_TC2_LO: tc2_q[31:0] <= merge(tc2_q[31:0], wd_q, ws_q) & TC_MASK[31:0];
            TSC_OFF_TC2_HI: tc2_q[63:32] <= merge(tc2_q[63:32], wd_q, ws_q) & TC_MASK[63:32];
            TSC_OFF_SC1_LO: sc1_q[31:0] <= merge(sc1_q[31:0], wd_q, ws_q) & SC_MASK[31:0];
            TSC_OFF_SC1_HI: begin
               // bits read as zero unless the element resets into el1
               sc1_q[63:32] <= merge(sc1_q[63:32], wd_q, ws_q) & SC_MASK[63:32] &
                  {32{RESET_EL1}}; // [R17]
            end
            TSC_OFF_HYP: if (ws_q[0]) hyp_q <= wd_q[3:0];
            TSC_OFF_IEN: if (ws_q[0]) ien_q <= wd_q[TSC_NEV-1:0];
            default: ;
         endcase
      end
   end

   // start gating: undefined, then trap, then trivial failure
   logic el0_ctl_live;
   tsc_res_type res_d;
   always_comb begin
      el0_ctl_live = !(hyp_q[0] && hyp_q[1]); // [R12]
      res_d = TSC_GO;
      // secure enable undefines el0..el2, hyp enable undefines el0..el1
      if (!HAS_TX || (!hyp_q[3] && start_req.el != TSC_EL3) ||
          (!hyp_q[2] && start_req.el != TSC_EL3 && start_req.el != TSC_EL2)) begin
         res_d = TSC_UNDEF; // [R15] [R19]
      end else if (start_req.el == TSC_EL0 && el0_ctl_live && !sc1_q[TSC_E0_BIT]) begin
         res_d = TSC_TRAP; // [R14] [R19]
      end else if (start_req.el == TSC_EL1 && !sc1_q[TSC_E1_BIT]) begin
         res_d = TSC_TRAP; // [R16]
      end else if (start_req.el == TSC_EL0 && el0_ctl_live && sc1_q[TSC_T0_BIT]) begin
         res_d = TSC_TRIV; // [R11] [R19]
      end else if (start_req.el == TSC_EL1 && sc1_q[TSC_T1_BIT]) begin
         res_d = TSC_TRIV; // [R13]
      end
   end

   // start result register; trap syndrome and failure cause
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_res <= '0;
         synd_q <= 25'h0;
         cause_q <= 8'h00;
      end else begin
         start_res.valid <= start_req.valid;
         start_res.res <= res_d;
         start_res.cause <= 8'h00;
         start_res.syndrome <= 25'h0;
         if (start_req.valid && res_d == TSC_TRAP) begin
            // only the destination register field is populated
            start_res.syndrome <= {15'h0, start_req.rd, 5'h00}; // [R10]
            synd_q <= {15'h0, start_req.rd, 5'h00}; // [R10]
         end
         if (start_req.valid && res_d == TSC_TRIV) begin
            // core discards tx state and writes this nonzero code to rd
            start_res.cause <= TSC_CAUSE_TRIVIAL; // [R18]
            cause_q <= TSC_CAUSE_TRIVIAL; // [R18]
         end
      end
   end

   // walk-disable gating for accesses from el0
   logic affected, wd_bit;
   always_comb begin
      affected = acc_req.from_el0 &&
         ((HAS_TX && acc_req.transactional) ||                                  // [R7]
          (HAS_VEC && (acc_req.nf_contig || acc_req.ff_gather_later)));       // [R8]
      wd_bit = acc_req.el2_regime ?
         (acc_req.upper ? tc2_q[TSC_UWD_BIT] : tc2_q[TSC_LWD_BIT]) :
         (acc_req.upper ? tc1_q[TSC_UWD_BIT] : tc1_q[TSC_LWD_BIT]); // [R6]
   end
   logic acc_block;
   assign acc_block = acc_req.valid && acc_req.tlb_miss && affected && wd_bit;
   // fail without exception and suppress the walk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_walk <= 1'b0;
         acc_fail <= 1'b0;
      end else begin
         acc_walk <= acc_req.valid && acc_req.tlb_miss && !acc_block; // [R5]
         acc_fail <= acc_block; // [R5]
      end
   end

   // sticky events: set wins over clear
   logic [TSC_NEV-1:0] ev;
   always_comb begin
      ev = '0;
      ev[TSC_EV_TRAP] = start_req.valid && res_d == TSC_TRAP;
      ev[TSC_EV_TRIV] = start_req.valid && res_d == TSC_TRIV;
      ev[TSC_EV_UNDEF] = start_req.valid && res_d == TSC_UNDEF;
      ev[TSC_EV_WFAIL] = acc_block;
   end
   logic [TSC_NEV-1:0] clr;
   assign clr = (wr_go && aw_q == TSC_OFF_ICLR && ws_q[0]) ? wd_q[TSC_NEV-1:0] : '0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= '0;
         irq <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~clr) | ev;
         irq <= |(((stat_q & ~clr) | ev) & ien_q);
      end
   end

   // read channel, one cycle to answer
   logic [31:0] rd_d;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         TSC_OFF_CTR_LO: rd_d = ctr_val[31:0];
         TSC_OFF_CTR_HI: rd_d = ctr_val[63:32];
         TSC_OFF_ISA_LO: rd_d = isa_val[31:0];
         TSC_OFF_ISA_HI: rd_d = isa_val[63:32];
         TSC_OFF_TC1_LO: rd_d = tc1_q[31:0];
         TSC_OFF_TC1_HI: rd_d = tc1_q[63:32];
         TSC_OFF_TC2_LO: rd_d = tc2_q[31:0];
         TSC_OFF_TC2_HI: rd_d = tc2_q[63:32];
         TSC_OFF_SC1_LO: rd_d = sc1_q[31:0];
         TSC_OFF_SC1_HI: rd_d = sc1_q[63:32];
         TSC_OFF_HYP: rd_d = {28'h0, hyp_q};
         TSC_OFF_STAT: rd_d = {{(32-TSC_NEV){1'b0}}, stat_q};
         TSC_OFF_IEN: rd_d = {{(32-TSC_NEV){1'b0}}, ien_q};
         TSC_OFF_SYND: rd_d = {1'b0, TSC_EXC_CLASS_START, synd_q};
         TSC_OFF_CAUSE: rd_d = {24'h0, cause_q};
         default: begin
            rd_d = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : tsc_regs
`default_nettype wire

/* File: dv/tsc_sva.sv */
// tsc_sva: port-level assertions for the transactional register bank.
// assumes one aclk domain, sync active-low aresetn; bound to tsc_regs.
`timescale 1ns/1ps
`default_nettype none
module tsc_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire tsc_pkg::tsc_start_type start_req,
   input wire tsc_pkg::tsc_result_type start_res,
   input wire tsc_pkg::tsc_acc_type acc_req,
   input wire logic acc_walk,
   input wire logic acc_fail
);
   import tsc_pkg::*;
   // all checks on aclk, quiet in reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // every start attempt is answered the next cycle
   a_start_answered: assert property (start_req.valid |=> start_res.valid)
      else $error("start attempt without result");
   // a trivial failure carries the nonzero trivial cause
   a_trivial_cause: assert property (start_res.valid && start_res.res == TSC_TRIV
      |-> start_res.cause == TSC_CAUSE_TRIVIAL) else $error("trivial cause wrong");
   // other outcomes carry no cause
   a_quiet_cause: assert property (start_res.valid && start_res.res != TSC_TRIV
      |-> start_res.cause == 8'h00) else $error("stray cause");
   // trap syndrome holds the destination register only
   a_syndrome_dest: assert property (start_req.valid ##1 start_res.res == TSC_TRAP
      |-> start_res.syndrome == {15'h0, $past(start_req.rd), 5'h0}) else $error("syndrome wrong");
   // a hit never walks nor fails
   a_hit_quiet: assert property (acc_req.valid && !acc_req.tlb_miss
      |=> !acc_walk && !acc_fail) else $error("hit produced walk or fail");
   // a miss either walks or fails, never both
   a_miss_one_way: assert property (acc_req.valid && acc_req.tlb_miss
      |=> acc_walk != acc_fail) else $error("miss outcome wrong");
   // unaffected access types always walk
   a_unaffected_walk: assert property (acc_req.valid && acc_req.tlb_miss &&
      !(acc_req.transactional || acc_req.nf_contig || acc_req.ff_gather_later)
      |=> acc_walk && !acc_fail) else $error("unaffected access blocked");
   // read answer stands until taken
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   // a taken read answer is retired, never repeated
   a_read_retires: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid repeated");
   // a taken write response is retired, never repeated
   a_write_retires: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid repeated");
endmodule : tsc_sva
bind tsc_regs tsc_sva chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .start_req(start_req), .start_res(start_res), .acc_req(acc_req), .acc_walk(acc_walk),
   .acc_fail(acc_fail));
`default_nettype wire

/* File: dv/transactional_sysreg_controls_tb.sv */
// transactional_sysreg_controls_tb: directed bench over AXI4-Lite and start/access ports.
// assumes tsc_regs with its bound checker; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module transactional_sysreg_controls_tb;
   import tsc_pkg::*;
   localparam logic [3:0] GRANULE = 4'h4; // granule log2 handed to the bank
   logic aclk = 1'b0, aresetn = 1'b0; // clock, sync reset
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // bus addresses
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write handshakes
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // read handshakes
   logic [31:0] s_axi_wdata = 32'h0; // write data
   logic [3:0] s_axi_wstrb = 4'hF; // whole words only
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_walk;
   logic acc_fail, irq; // gating and interrupt outputs
   logic [1:0] s_axi_bresp, s_axi_rresp; // responses
   logic [31:0] s_axi_rdata; // read data
   tsc_start_type start_req = '0; // start attempt
   tsc_result_type start_res; // start outcome
   tsc_acc_type acc_req = '0; // memory access
   int miscompares = 0; // mismatches
   int n_tests = 0; // comparisons
   logic [1:0] resp; // last bus response
   logic [31:0] rd; // last read word
   // 25 ns clock
   always #12.5 aclk = ~aclk;
   tsc_regs #(.GRANULE_LOG2(GRANULE)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_req, .start_res,
      .acc_req, .acc_walk, .acc_fail, .irq);
   // verdict and the single end of the run
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   // compare seen against expected
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // cut a hung handshake short
   task automatic bound(input int n);
      if (n >= 64) begin
         miscompares++;
         $display("CHECK FAILED handshake expected answer seen none");
         tally_and_finish();
      end
   endtask : bound
   // one write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      logic aw_ok = 1'b0;
      logic w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         bound(++n);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) begin
         @(posedge aclk);
         bound(++n);
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   // one read: rready held with the request until rvalid is sampled high
   task automatic axi_rd(input logic [7:0] a);
      int n = 0;
      logic got = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         bound(++n);
         if (s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid === 1'b1) begin
            got = 1'b1;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : axi_rd
   // one start attempt, outcome checked one cycle after the pulse
   task automatic start(input tsc_el_type el, input logic [4:0] r, input tsc_res_type res);
      tsc_result_type e;
      e.valid = 1'b1;
      e.res = res;
      e.cause = (res == TSC_TRIV) ? TSC_CAUSE_TRIVIAL : 8'h00;
      e.syndrome = (res == TSC_TRAP) ? {15'h0, r, 5'h0} : 25'h0;
      @(posedge aclk);
      start_req <= tsc_start_type'({1'b1, el, r});
      @(posedge aclk);
      start_req.valid <= 1'b0;
      @(posedge aclk);
      chk(start_res, e, "start result");
   endtask : start
   // one access: v is valid,miss,upper,el2,el0,tx,nf,ffg; x is walk,fail
   task automatic acc(input logic [7:0] v, input logic [1:0] x);
      @(posedge aclk);
      acc_req <= tsc_acc_type'(v);
      @(posedge aclk);
      acc_req.valid <= 1'b0;
      @(posedge aclk);
      chk({acc_walk, acc_fail}, x, "walk gating");
   endtask : acc
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(TSC_OFF_CTR_LO);
      chk(rd[23:20], GRANULE, "granule");
      chk((rd[23:20] == 4'h0) ? 36'd512 : (36'd1 << rd[23:20]), 36'd1 << GRANULE, "words");
      axi_rd(TSC_OFF_ISA_LO);
      chk(rd[27:24], TSC_FEAT_ALL, "feature");
      axi_rd(TSC_OFF_SC1_HI);
      chk(rd, 32'h0, "control reset");
      axi_rd(8'h40);
      chk({resp, rd}, {2'b10, 32'h0}, "unmapped read");
      axi_wr(TSC_OFF_CTR_LO, 32'hFFFF_FFFF);
      chk(resp, 2'b10, "read-only write");
      axi_rd(TSC_OFF_CTR_LO);
      chk({resp, rd[23:20]}, {2'b00, GRANULE}, "read-only granule");
      start(TSC_EL1, 5'h1D, TSC_TRAP);
      axi_rd(TSC_OFF_SYND);
      chk(rd, {1'b0, TSC_EXC_CLASS_START, 15'h0, 5'h1D, 5'h0}, "syndrome");
      start(TSC_EL0, 5'h03, TSC_TRAP);
      axi_wr(TSC_OFF_SC1_HI, 32'h003C_0000);
      start(TSC_EL0, 5'h1F, TSC_TRIV);
      start(TSC_EL1, 5'h00, TSC_TRIV);
      axi_rd(TSC_OFF_CAUSE);
      chk(rd, 32'h1, "cause");
      axi_wr(TSC_OFF_SC1_HI, 32'h0030_0000);
      start(TSC_EL0, 5'h01, TSC_GO);
      start(TSC_EL1, 5'h02, TSC_GO);
      axi_wr(TSC_OFF_SC1_HI, 32'h0);
      axi_wr(TSC_OFF_HYP, 32'hF);
      start(TSC_EL0, 5'h04, TSC_GO);
      start(TSC_EL1, 5'h05, TSC_TRAP);
      axi_wr(TSC_OFF_HYP, 32'h8);
      start(TSC_EL0, 5'h06, TSC_UNDEF);
      start(TSC_EL1, 5'h07, TSC_UNDEF);
      axi_rd(TSC_OFF_ISA_LO);
      chk(rd[27:24], TSC_FEAT_NONE, "feature off");
      axi_wr(TSC_OFF_HYP, 32'hC);
      axi_wr(TSC_OFF_TC1_HI, 32'h0060_0000);
      acc(8'hEA, 2'b01);
      acc(8'hCC, 2'b01);
      acc(8'hE9, 2'b01);
      acc(8'hAA, 2'b00);
      acc(8'hE8, 2'b10);
      acc(8'hFA, 2'b10);
      axi_wr(TSC_OFF_TC1_HI, 32'h0020_0000);
      acc(8'hEA, 2'b10);
      acc(8'hCA, 2'b01);
      axi_rd(TSC_OFF_STAT);
      chk({irq, rd}, {1'b0, 32'hF}, "status masked");
      axi_wr(TSC_OFF_IEN, 32'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1, "irq raised");
      axi_wr(TSC_OFF_ICLR, 32'hF);
      axi_rd(TSC_OFF_STAT);
      chk({irq, rd}, 33'h0, "status cleared");
      tally_and_finish();
   end
endmodule : transactional_sysreg_controls_tb
`default_nettype wire
